// ---- hdl/apsc_defs.svh ----
// constants for the analyzer pattern sync control
`ifndef APSC_DEFS_SVH
`define APSC_DEFS_SVH
`define APSC_BLOCK_BITS    13'h1000
`define APSC_BLOCK_LAST    13'h0FFF
`define APSC_PRBS_THRESH   13'h0400
`define APSC_WORD_THRESH   13'h0080
`define APSC_CNT_W         13
`define APSC_ERRCNT_W      32
`define APSC_ZERO_CNT      13'h0000
`define APSC_ZERO_ERR      32'h0000_0000
`endif

// ---- hdl/apsc_pkg.sv ----
// types for the analyzer pattern sync control
package apsc_pkg;
  typedef enum logic [1:0] {
    APSC_MODE_MANUAL = 2'b00,
    APSC_MODE_REALIGN = 2'b01,
    APSC_MODE_HUNT = 2'b10
  } apsc_mode_t;
endpackage

// ---- hdl/apsc_rate_win.sv ----
// error-rate window: counts errors per fixed block of received bits
`timescale 1ns/100ps
`include "apsc_defs.svh"
module apsc_rate_win (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // bit stream compare
  input  wire logic                    bit_valid,
  input  wire logic                    bit_error,
  input  wire logic                    word_pattern,
  // result
  output logic                         block_done,
  output logic                         block_over
);
  logic [`APSC_CNT_W-1:0] bit_cnt_ff;
  logic [`APSC_CNT_W-1:0] nxt_bit_cnt;
  logic [`APSC_CNT_W-1:0] err_cnt_ff;
  logic [`APSC_CNT_W-1:0] nxt_err_cnt;
  logic [`APSC_CNT_W-1:0] thresh;
  logic                   last_bit;
  logic [`APSC_CNT_W-1:0] err_total;

  always_comb begin
    thresh      = word_pattern ? `APSC_WORD_THRESH : `APSC_PRBS_THRESH;
    last_bit    = bit_valid && (bit_cnt_ff == `APSC_BLOCK_LAST);
    err_total   = err_cnt_ff + {{(`APSC_CNT_W-1){1'b0}}, bit_error};
    nxt_bit_cnt = bit_cnt_ff;
    nxt_err_cnt = err_cnt_ff;
    if (bit_valid) begin
      nxt_bit_cnt = last_bit ? `APSC_ZERO_CNT : bit_cnt_ff + 13'h0001;
      nxt_err_cnt = last_bit ? `APSC_ZERO_CNT : err_total;
    end
    block_done = last_bit;
    // over threshold when errors reach the word or PRBS threshold count, chosen by word_pattern, in the block
    block_over = last_bit && (err_total >= thresh);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_ff <= `APSC_ZERO_CNT;
      err_cnt_ff <= `APSC_ZERO_CNT;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      err_cnt_ff <= nxt_err_cnt;
    end
  end
endmodule

// ---- hdl/apsc_sync_ctrl.sv ----
// pattern sync control: lock, hunt/hold modes, history and sync-loss
`timescale 1ns/100ps
`include "apsc_defs.svh"
module apsc_sync_ctrl (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // received stream compare
  input  wire logic                      bit_valid,
  input  wire logic                      bit_error,
  input  wire logic                      clock_slip,
  input  wire logic                      word_pattern,
  input  wire logic                      reference_input_select,
  // user controls, one-cycle presses
  input  wire logic                      hunt_press,
  input  wire logic                      hold_press,
  input  wire logic                      interval_start,
  input  wire logic                      sync_loss_clear,
  input  wire logic                      history_clear,
  // setup search and counter-clear requests, one-cycle pulses
  output logic                           full_search,
  output logic                           align_search,
  output logic                           counters_clear,
  // status
  output logic                           lock,
  output logic                           hunt_on,
  output logic                           hold_on,
  output logic                           sync_loss,
  output logic                           error_history,
  output logic                           slip_history,
  output logic [`APSC_ERRCNT_W-1:0]      error_count
);
  logic block_done;
  logic block_over;

  apsc_rate_win u_win (
    .clk          (clk),
    .nrst         (nrst),
    .bit_valid    (bit_valid),
    .bit_error    (bit_error),
    .word_pattern (word_pattern),
    .block_done   (block_done),
    .block_over   (block_over)
  );

  apsc_pkg::apsc_mode_t mode_ff, nxt_mode;
  logic                 lock_ff, nxt_lock;
  logic                 loss_ff, nxt_loss;
  logic                 ehist_ff, nxt_ehist;
  logic                 shist_ff, nxt_shist;
  logic                 full_ff, nxt_full;
  logic                 align_ff, nxt_align;
  logic                 cclr_ff, nxt_cclr;
  logic                 armed_ff, nxt_armed;
  logic [`APSC_ERRCNT_W-1:0] ecnt_ff, nxt_ecnt;
  logic                 lock_lost;
  logic                 lock_gain;

  always_comb begin
    nxt_mode  = mode_ff;
    nxt_lock  = lock_ff;
    nxt_loss  = loss_ff;
    nxt_ehist = ehist_ff;
    nxt_shist = shist_ff;
    nxt_full  = 1'b0;
    nxt_align = 1'b0;
    nxt_cclr  = 1'b0;
    nxt_armed = armed_ff;
    nxt_ecnt  = ecnt_ff;
    // lock follows the block's rate versus threshold
    if (block_done) begin
      nxt_lock = !block_over;
    end
    lock_lost = block_done && block_over && lock_ff;
    lock_gain = block_done && !block_over && !lock_ff;
    // mode selection, a hunt press wins over a hold press in the same cycle
    if (hunt_press) begin
      nxt_mode = (mode_ff == apsc_pkg::APSC_MODE_HUNT) ? apsc_pkg::APSC_MODE_MANUAL
                                                      : apsc_pkg::APSC_MODE_HUNT;
    end else if (hold_press) begin
      nxt_mode = (mode_ff == apsc_pkg::APSC_MODE_REALIGN) ? apsc_pkg::APSC_MODE_MANUAL
                                                         : apsc_pkg::APSC_MODE_REALIGN;
    end
    // immediate resync on enabling hunting, unless reference_input_select is set
    if (hunt_press && mode_ff != apsc_pkg::APSC_MODE_HUNT && !reference_input_select) begin
      nxt_full = 1'b1;
    end
    // new interval releases hold and allows one search
    if (interval_start) begin
      if (mode_ff == apsc_pkg::APSC_MODE_REALIGN && !hold_press && !hunt_press) begin
        nxt_mode = apsc_pkg::APSC_MODE_MANUAL;
      end
      nxt_armed = 1'b1;
    end
    if (block_done && block_over) begin
      unique case (mode_ff)
        // full setup search on loss of lock
        apsc_pkg::APSC_MODE_HUNT: nxt_full = lock_ff || armed_ff || nxt_full;
        // alignment-only search while rate reaches threshold
        apsc_pkg::APSC_MODE_MANUAL: nxt_align = 1'b1;
        // held: keep setup, keep counting
        apsc_pkg::APSC_MODE_REALIGN: nxt_align = 1'b0;
        default: nxt_align = 1'b0;
      endcase
      nxt_armed = 1'b0;
    end
    // sticky loss, set wins over clear
    if (sync_loss_clear) begin
      nxt_loss = 1'b0;
    end
    if (lock_lost) begin
      nxt_loss = 1'b1;
    end
    if (history_clear) begin
      nxt_ehist = 1'b0;
      nxt_shist = 1'b0;
    end
    if (bit_valid && bit_error) begin
      nxt_ehist = 1'b1;
      nxt_ecnt  = ecnt_ff + 32'h0000_0001;
    end
    if (clock_slip) begin
      nxt_shist = 1'b1;
    end
    if (interval_start) begin
      nxt_ecnt = `APSC_ZERO_ERR;
    end
    // regained under hunting: clear history and counters
    if (lock_gain && mode_ff == apsc_pkg::APSC_MODE_HUNT) begin
      nxt_ehist = 1'b0;
      nxt_shist = 1'b0;
      nxt_ecnt  = `APSC_ZERO_ERR;
      nxt_cclr  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff  <= apsc_pkg::APSC_MODE_MANUAL;
      lock_ff  <= 1'b0;
      loss_ff  <= 1'b0;
      ehist_ff <= 1'b0;
      shist_ff <= 1'b0;
      full_ff  <= 1'b0;
      align_ff <= 1'b0;
      cclr_ff  <= 1'b0;
      armed_ff <= 1'b0;
      ecnt_ff  <= `APSC_ZERO_ERR;
    end else begin
      mode_ff  <= nxt_mode;
      lock_ff  <= nxt_lock;
      loss_ff  <= nxt_loss;
      ehist_ff <= nxt_ehist;
      shist_ff <= nxt_shist;
      full_ff  <= nxt_full;
      align_ff <= nxt_align;
      cclr_ff  <= nxt_cclr;
      armed_ff <= nxt_armed;
      ecnt_ff  <= nxt_ecnt;
    end
  end

  assign full_search    = full_ff;
  assign align_search   = align_ff;
  assign counters_clear = cclr_ff;
  assign lock           = lock_ff;
  assign hunt_on        = (mode_ff == apsc_pkg::APSC_MODE_HUNT);
  assign hold_on        = (mode_ff == apsc_pkg::APSC_MODE_REALIGN);
  assign sync_loss      = loss_ff;
  assign error_history  = ehist_ff;
  assign slip_history   = shist_ff;
  assign error_count    = ecnt_ff;

  // checks
  a_modes_exclusive: assert property (@(posedge clk) disable iff (!nrst)
    !(hunt_on && hold_on)) else $error("hunt and hold both on");
  a_lock_follows: assert property (@(posedge clk) disable iff (!nrst)
    block_done |=> (lock == !$past(block_over))) else $error("lock wrong");
  a_loss_sticky: assert property (@(posedge clk) disable iff (!nrst)
    sync_loss && !sync_loss_clear |=> sync_loss) else $error("loss dropped");
  a_loss_sets: assert property (@(posedge clk) disable iff (!nrst)
    block_done && block_over && lock |=> sync_loss) else $error("loss not set");
  a_hold_no_align: assert property (@(posedge clk) disable iff (!nrst)
    hold_on && block_over |=> !align_search) else $error("align in hold");
  a_manual_align: assert property (@(posedge clk) disable iff (!nrst)
    !hunt_on && !hold_on && block_over |=> align_search
    && (full_search == $past(hunt_press && !reference_input_select)))
    else $error("no align search");
  a_hunt_start: assert property (@(posedge clk) disable iff (!nrst)
    hunt_press && !hunt_on && !reference_input_select |=> full_search && hunt_on)
    else $error("no immediate resync");
  a_hunt_regain: assert property (@(posedge clk) disable iff (!nrst)
    hunt_on && block_done && !block_over && !lock |=> error_count == `APSC_ZERO_ERR
    && !error_history && !slip_history && counters_clear) else $error("regain clear");
  a_hold_toggle: assert property (@(posedge clk) disable iff (!nrst)
    hold_press && !hunt_press && !hold_on |=> hold_on) else $error("hold no toggle");
  a_interval_release: assert property (@(posedge clk) disable iff (!nrst)
    hold_on && interval_start && !hold_press && !hunt_press |=> !hold_on)
    else $error("hold not released");
  c_lock_loss: cover property (@(posedge clk) disable iff (!nrst) lock ##1 !lock);
  c_hunt_regain: cover property (@(posedge clk) disable iff (!nrst) hunt_on && counters_clear);
  c_hold_release: cover property (@(posedge clk) disable iff (!nrst) hold_on ##1 !hold_on);
endmodule

// ---- sim/apsc_tx_model.sv ----
// far-side transmitter model: sends one block of compared bits on request
`timescale 1ns/100ps
module apsc_tx_model (
  // clock and request
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [12:0] errs,
  // compared bit stream
  output logic             bit_valid,
  output logic             bit_error,
  output logic             busy
);
  int unsigned idx;
  initial begin
    bit_valid = 1'h0;
    bit_error = 1'h0;
    busy      = 1'h0;
    idx       = 0;
  end
  // first errs bits of the block mismatch; error line toggles between blocks
  always @(negedge clk) begin
    if (go && !busy) begin
      busy <= 1'h1;
      idx  <= 0;
    end else if (busy && idx < 4096) begin
      bit_valid <= 1'h1;
      bit_error <= (idx < errs);
      idx       <= idx + 1;
    end else begin
      bit_valid <= 1'h0;
      bit_error <= ~bit_error;
      busy      <= 1'h0;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the pattern sync control
`timescale 1ns/100ps
module testbench;
  typedef struct {logic wp; logic [12:0] e; logic lk; logic sl; logic al;} apsc_row_t;
  apsc_row_t rows [7] = '{'{1'h0, 13'h0000, 1'h1, 1'h0, 1'h0},
    '{1'h0, 13'h0400, 1'h0, 1'h1, 1'h1}, '{1'h0, 13'h03FF, 1'h1, 1'h1, 1'h0},
    '{1'h1, 13'h0080, 1'h0, 1'h1, 1'h1}, '{1'h1, 13'h007F, 1'h1, 1'h1, 1'h0},
    '{1'h0, 13'h0400, 1'h0, 1'h1, 1'h1}, '{1'h1, 13'h0FFF, 1'h0, 1'h1, 1'h1}};
  logic        clk, nrst, go, bit_valid, bit_error, busy, word_pattern, ref_sel;
  logic [12:0] errs;
  logic [5:0]  prs;
  logic        full_search, align_search, counters_clear, lock, hunt_on, hold_on;
  logic        sync_loss, error_history, slip_history;
  logic [31:0] error_count;
  int          bad_count, num_checks, n_full, n_align, n_clr, f0, a0, c0, i;
  apsc_sync_ctrl apsc_sync_ctrl_i (.clk(clk), .nrst(nrst), .bit_valid(bit_valid),
    .bit_error(bit_error), .clock_slip(prs[5]), .word_pattern(word_pattern),
    .reference_input_select(ref_sel), .hunt_press(prs[0]), .hold_press(prs[1]),
    .interval_start(prs[2]), .sync_loss_clear(prs[3]), .history_clear(prs[4]),
    .full_search(full_search), .align_search(align_search),
    .counters_clear(counters_clear), .lock(lock), .hunt_on(hunt_on), .hold_on(hold_on),
    .sync_loss(sync_loss), .error_history(error_history), .slip_history(slip_history),
    .error_count(error_count));
  apsc_tx_model apsc_tx_model_i (.clk(clk), .go(go), .errs(errs),
    .bit_valid(bit_valid), .bit_error(bit_error), .busy(busy));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // request pulse counters
  always @(posedge clk) begin
    if (full_search === 1'h1) n_full++;
    if (align_search === 1'h1) n_align++;
    if (counters_clear === 1'h1) n_clr++;
  end
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic snap();
    f0 = n_full;
    a0 = n_align;
    c0 = n_clr;
  endtask
  task automatic push(input logic [5:0] p);
    snap();
    @(negedge clk) prs <= p;
    @(negedge clk) prs <= 6'h00;
    repeat (2) @(negedge clk);
  endtask
  task automatic blk(input logic [12:0] e);
    int k;
    snap();
    errs = e;
    @(negedge clk) go <= 1'h1;
    @(negedge clk) go <= 1'h0;
    @(negedge clk);
    for (k = 0; k < 5000 && busy; k++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    nrst = 1'h0;
    go = 1'h0;
    errs = 13'h0000;
    prs = 6'h00;
    word_pattern = 1'h0;
    ref_sel = 1'h0;
    repeat (10) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    check("status", {lock, hunt_on, hold_on, sync_loss, error_count}, 32'h0);
    // manual mode: thresholds, lock, latched loss, align per bad block
    for (i = 0; i < 7; i++) begin
      word_pattern = rows[i].wp;
      blk(rows[i].e);
      check("lock", lock, rows[i].lk);
      check("sync_loss", sync_loss, rows[i].sl);
      check("align", 32'(n_align - a0), rows[i].al);
      check("full", 32'(n_full - f0), 32'h0);
    end
    push(6'h08);
    check("sync_loss_clr", sync_loss, 1'h0);
    push(6'h04);
    push(6'h02);
    check("hold_on", {hunt_on, hold_on}, 32'h1);
    blk(13'h0400);
    check("hold_align", 32'(n_align - a0), 32'h0);
    check("hold_count", error_count, 32'h400);
    push(6'h04);
    check("released", {hold_on, error_count}, 32'h0);
    blk(13'h0400);
    check("fresh_align", 32'(n_align - a0), 32'h1);
    push(6'h02);
    push(6'h02);
    check("hold_toggle", hold_on, 1'h0);
    push(6'h20);
    check("slip_hist", slip_history, 1'h1);
    push(6'h01);
    check("hunt_on", {hunt_on, hold_on}, 32'h2);
    check("hunt_start", 32'(n_full - f0), 32'h1);
    blk(13'h0000);
    check("regain", {lock, error_history, slip_history}, 32'h4);
    check("cnt_clear", 32'(n_clr - c0), 32'h1);
    check("cnt_zero", error_count, 32'h0);
    blk(13'h0400);
    check("hunt_full", 32'(n_full - f0), 32'h1);
    check("hunt_align", 32'(n_align - a0), 32'h0);
    // unlocked under hunting: only a new interval re-arms the full search
    push(6'h04);
    blk(13'h0400);
    check("armed_full", 32'(n_full - f0), 32'h1);
    check("err_hist", {error_history, slip_history}, 32'h2);
    push(6'h10);
    check("hist_clr", {error_history, slip_history}, 32'h0);
    push(6'h02);
    check("hold_wins", {hunt_on, hold_on}, 32'h1);
    // reference input selected: hunting starts without a full search
    ref_sel = 1'h1;
    push(6'h01);
    check("ref_hunt", {hunt_on, hold_on}, 32'h2);
    check("ref_no_full", 32'(n_full - f0), 32'h0);
    ref_sel = 1'h0;
    // mid-run reset with hunting on and sync loss latched
    nrst = 1'h0;
    @(negedge clk);
    check("in_reset", {lock, hunt_on, hold_on, sync_loss, error_history, slip_history,
      full_search, align_search, counters_clear, error_count}, 48'h0);
    repeat (2) @(negedge clk);
    nrst = 1'h1;
    repeat (2) @(negedge clk);
    check("after_reset", {lock, hunt_on, hold_on, sync_loss, error_history, slip_history,
      full_search, align_search, counters_clear, error_count}, 48'h0);
    tally_and_finish();
  end
endmodule
